// *** hdl/sys_remap_defs.svh ***
// Offsets, field positions, reset values and encodings for the remap and soft reset bank.
// Assumes an APB master on the system clock that decodes full 32-bit byte addresses.
`ifndef SYS_REMAP_DEFS_SVH
`define SYS_REMAP_DEFS_SVH

`define VEC_SRC_SEL_ADDR 32'h4004_8000
`define PERIPH_RST_ADDR 32'h4004_8004

`define MAP_WIDTH 2
`define MAP_BOOT_ROM 2'h0
`define MAP_SRAM 2'h1
`define MAP_FLASH 2'h2
`define MAP_RESERVED 2'h3
`define MAP_RESET_VAL 2'h2

`define PRST_WIDTH 13
`define PRST_RESET_VAL 13'h1FFF
`define PRST_FIRST_SERIAL 0
`define PRST_SECOND_SERIAL 1
`define PRST_BAUD_FRACTION 2
`define PRST_FIRST_ASYNC 3
`define PRST_SECOND_ASYNC 4
`define PRST_THIRD_ASYNC 5
`define PRST_I2C 6
`define PRST_MULTI_RATE 7
`define PRST_STATE_TIMER 8
`define PRST_WAKEUP 9
`define PRST_GPIO 10
`define PRST_FLASH 11
`define PRST_COMPARATOR 12

`define VEC_REGION_BASE 32'h0000_0000
`define VEC_REGION_TOP 32'h0000_0200

`endif

// *** hdl/sys_remap_pkg.sv ***
// Types shared by the remap and soft reset bank.
// Assumes the memory decoder understands the source encoding below.
package sys_remap_pkg;
  typedef enum logic [1:0] {src_boot_rom, src_sram, src_flash} mem_src_t;
endpackage : sys_remap_pkg

// *** hdl/sys_remap_and_periph_reset.sv ***
// APB register bank: vector region source select and peripheral soft reset control.
// Assumes APB master on the same clock; decoder presents the fetch address each cycle.
//
// Local design decision: the APB register port.
`include "sys_remap_defs.svh"

module sys_remap_and_periph_reset (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory decoder
  input wire logic [31:0] mem_addr,
  output sys_remap_pkg::mem_src_t mem_src,
  output logic vec_redirect,
  output logic [1:0] vector_region_source_select,
  // Peripheral resets
  output logic first_serial_periph_reset_n,
  output logic second_serial_periph_reset_n,
  output logic baud_fraction_gen_reset_n,
  output logic first_async_port_reset_n,
  output logic second_async_port_reset_n,
  output logic third_async_port_reset_n,
  output logic i2c_reset_n,
  output logic multi_rate_timer_reset_n,
  output logic state_timer_reset_n,
  output logic wakeup_timer_reset_n,
  output logic gpio_reset_n,
  output logic flash_ctrl_reset_n,
  output logic comparator_reset_n
);

  logic [1:0] map_q;
  logic [12:0] prst_q;
  logic [31:0] rdata_q;
  logic setup;
  logic access;
  logic hit_map;
  logic hit_prst;
  logic wr_map;
  logic wr_prst;
  logic in_region;
  logic rd_setup;
  logic [31:0] rdata_d;
  logic [12:0] prst_lane_en;
  localparam logic [12:0] prst_reset_val = `PRST_RESET_VAL;

  // Full 32-bit match, so the bank does not alias across the page
  function automatic logic addr_is(input logic [31:0] addr, input logic [31:0] reg_addr);
    addr_is = (addr == reg_addr);
  endfunction : addr_is

  // Zero wait states: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_map = addr_is(paddr, `VEC_SRC_SEL_ADDR);
  assign hit_prst = addr_is(paddr, `PERIPH_RST_ADDR);
  assign pslverr = access && !hit_map && !hit_prst;
  assign wr_map = access && pwrite && hit_map && pstrb[0];
  assign wr_prst = access && pwrite && hit_prst;

  // Code 0x3 is dropped so the decoder never sees an undefined source
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      map_q <= `MAP_RESET_VAL;
    else if (wr_map && (pwdata[1:0] != `MAP_RESERVED))
      map_q <= pwdata[1:0];
  end

  // Byte lanes: bits 7:0 on lane 0, bits 12:8 on lane 1
  for (genvar g = 0; g < `PRST_WIDTH; g++)
  begin : g_prst_bit
    assign prst_lane_en[g] = wr_prst && pstrb[g / 8];
    always_ff @(posedge clock or posedge sys_rst)
    begin
      if (sys_rst)
        prst_q[g] <= prst_reset_val[g];
      else if (prst_lane_en[g])
        prst_q[g] <= pwdata[g];
    end
  end

  // Read data captured in the setup cycle so prdata comes from a flop
  assign rd_setup = setup && !pwrite;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (addr_is(paddr, `VEC_SRC_SEL_ADDR))
      rdata_d = {30'h0000_0000, map_q};
    else if (addr_is(paddr, `PERIPH_RST_ADDR))
      rdata_d = {19'h0_0000, prst_q};
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else if (rd_setup)
      rdata_q <= rdata_d;
  end
  assign prdata = rdata_q;

  // Region decode; everything at or above the top always goes to flash
  assign in_region = (mem_addr < `VEC_REGION_TOP);
  assign vec_redirect = in_region && (map_q != `MAP_FLASH);
  assign vector_region_source_select = map_q;

  always_comb
  begin
    mem_src = sys_remap_pkg::src_flash;
    if (in_region)
    begin
      case (map_q)
        `MAP_BOOT_ROM: mem_src = sys_remap_pkg::src_boot_rom;
        `MAP_SRAM: mem_src = sys_remap_pkg::src_sram;
        `MAP_FLASH: mem_src = sys_remap_pkg::src_flash;
        default: mem_src = sys_remap_pkg::src_flash;
      endcase
    end
  end

  // Soft resets straight from the register flops, so no glitches reach peripherals
  assign first_serial_periph_reset_n = prst_q[`PRST_FIRST_SERIAL];
  assign second_serial_periph_reset_n = prst_q[`PRST_SECOND_SERIAL];
  assign baud_fraction_gen_reset_n = prst_q[`PRST_BAUD_FRACTION];
  assign first_async_port_reset_n = prst_q[`PRST_FIRST_ASYNC];
  assign second_async_port_reset_n = prst_q[`PRST_SECOND_ASYNC];
  assign third_async_port_reset_n = prst_q[`PRST_THIRD_ASYNC];
  assign i2c_reset_n = prst_q[`PRST_I2C];
  assign multi_rate_timer_reset_n = prst_q[`PRST_MULTI_RATE];
  assign state_timer_reset_n = prst_q[`PRST_STATE_TIMER];
  assign wakeup_timer_reset_n = prst_q[`PRST_WAKEUP];
  assign gpio_reset_n = prst_q[`PRST_GPIO];
  assign flash_ctrl_reset_n = prst_q[`PRST_FLASH];
  assign comparator_reset_n = prst_q[`PRST_COMPARATOR];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_map_reset_flash: assert property ($past(sys_rst) |-> map_q == `MAP_FLASH)
    else $error("Selector not flash after reset");
  a_map_no_reserved: assert property (wr_map && pwdata[1:0] == `MAP_RESERVED |=> map_q == $past(map_q))
    else $error("Reserved selector code accepted");
  a_boot_rom_src: assert property (map_q == `MAP_BOOT_ROM && mem_addr < `VEC_REGION_TOP
    |-> mem_src == sys_remap_pkg::src_boot_rom && vec_redirect)
    else $error("Boot ROM not selected");
  a_sram_src: assert property (map_q == `MAP_SRAM && mem_addr <= 32'h0000_01FF
    |-> mem_src == sys_remap_pkg::src_sram && vec_redirect)
    else $error("SRAM not selected");
  a_flash_src: assert property (map_q == `MAP_FLASH |-> mem_src == sys_remap_pkg::src_flash && !vec_redirect)
    else $error("Flash mode redirected");
  a_high_addr_flash: assert property (mem_addr >= 32'h0000_0200 |-> mem_src == sys_remap_pkg::src_flash)
    else $error("Address above region redirected");
  a_write_zero_holds: assert property (wr_prst && pstrb[0] && !pwdata[0]
    |=> !first_serial_periph_reset_n)
    else $error("Soft reset not asserted");
  a_zero_stays_held: assert property (!first_serial_periph_reset_n && !(wr_prst && pstrb[0])
    |=> !first_serial_periph_reset_n)
    else $error("Soft reset not held");
  a_write_one_release: assert property (wr_prst && pstrb[1] && pwdata[12]
    |=> comparator_reset_n && flash_ctrl_reset_n == $past(pwdata[11]))
    else $error("Soft reset not released");
  a_prst_reset_ones: assert property ($past(sys_rst) |-> prst_q == 13'h1FFF && gpio_reset_n)
    else $error("Soft resets not released at reset");
  a_rsvd_read_zero: assert property (access && !pwrite && hit_prst
    |-> prdata[31:13] == 19'h0_0000 && prdata[12:0] == prst_q)
    else $error("Reserved bits not zero");
  a_map_read_back: assert property (access && !pwrite && hit_map |-> prdata == {30'h0000_0000, map_q})
    else $error("Selector read back wrong");
  a_no_reserved_code: assert property (map_q != `MAP_RESERVED)
    else $error("Selector holds reserved code");
  a_high_no_redirect: assert property (mem_addr >= `VEC_REGION_TOP |-> !vec_redirect)
    else $error("Redirect above region");
  a_unmapped_zero: assert property (access && !pwrite && paddr != `VEC_SRC_SEL_ADDR
    && paddr != `PERIPH_RST_ADDR |-> prdata == 32'h0000_0000 && pslverr)
    else $error("Unmapped read not zero");

  // One check per peripheral output, tied to its own bus bit
  a_first_serial_bit: assert property (wr_prst && pstrb[0]
    |=> first_serial_periph_reset_n == $past(pwdata[`PRST_FIRST_SERIAL]))
    else $error("First serial reset on wrong bit");
  a_second_serial_bit: assert property (wr_prst && pstrb[0]
    |=> second_serial_periph_reset_n == $past(pwdata[`PRST_SECOND_SERIAL]))
    else $error("Second serial reset on wrong bit");
  a_baud_fraction_bit: assert property (wr_prst && pstrb[0]
    |=> baud_fraction_gen_reset_n == $past(pwdata[`PRST_BAUD_FRACTION]))
    else $error("Baud fraction reset on wrong bit");
  a_first_async_bit: assert property (wr_prst && pstrb[0]
    |=> first_async_port_reset_n == $past(pwdata[`PRST_FIRST_ASYNC]))
    else $error("First async reset on wrong bit");
  a_second_async_bit: assert property (wr_prst && pstrb[0]
    |=> second_async_port_reset_n == $past(pwdata[`PRST_SECOND_ASYNC]))
    else $error("Second async reset on wrong bit");
  a_third_async_bit: assert property (wr_prst && pstrb[0]
    |=> third_async_port_reset_n == $past(pwdata[`PRST_THIRD_ASYNC]))
    else $error("Third async reset on wrong bit");
  a_i2c_bit: assert property (wr_prst && pstrb[0]
    |=> i2c_reset_n == $past(pwdata[`PRST_I2C]))
    else $error("I2C reset on wrong bit");
  a_multi_rate_bit: assert property (wr_prst && pstrb[0]
    |=> multi_rate_timer_reset_n == $past(pwdata[`PRST_MULTI_RATE]))
    else $error("Multi-rate timer reset on wrong bit");
  a_state_timer_bit: assert property (wr_prst && pstrb[1]
    |=> state_timer_reset_n == $past(pwdata[`PRST_STATE_TIMER]))
    else $error("State timer reset on wrong bit");
  a_wakeup_timer_bit: assert property (wr_prst && pstrb[1]
    |=> wakeup_timer_reset_n == $past(pwdata[`PRST_WAKEUP]))
    else $error("Wake-up timer reset on wrong bit");
  a_gpio_bit: assert property (wr_prst && pstrb[1]
    |=> gpio_reset_n == $past(pwdata[`PRST_GPIO]))
    else $error("GPIO reset on wrong bit");
  a_flash_ctrl_bit: assert property (wr_prst && pstrb[1]
    |=> flash_ctrl_reset_n == $past(pwdata[`PRST_FLASH]))
    else $error("Flash controller reset on wrong bit");
  a_comparator_bit: assert property (wr_prst && pstrb[1]
    |=> comparator_reset_n == $past(pwdata[`PRST_COMPARATOR]))
    else $error("Comparator reset on wrong bit");

  // Every bit follows its own lane and nothing else
  for (genvar b = 0; b < `PRST_WIDTH; b++)
  begin : g_prst_check
    a_bit_follows_write: assert property (@(posedge clock) disable iff (sys_rst)
      wr_prst && pstrb[b / 8] |=> prst_q[b] == $past(pwdata[b]))
      else $error("Soft reset bit missed write");
    a_bit_keeps_value: assert property (@(posedge clock) disable iff (sys_rst)
      !(wr_prst && pstrb[b / 8]) |=> $stable(prst_q[b]))
      else $error("Soft reset bit changed without write");
  end

  c_soft_reset: cover property (wr_prst && pstrb[0] && !pwdata[0] ##1 !first_serial_periph_reset_n);
  c_boot_rom: cover property (wr_map && pwdata[1:0] == `MAP_BOOT_ROM ##1 vec_redirect);
  c_reserved_try: cover property (wr_map && pwdata[1:0] == `MAP_RESERVED);
  c_unmapped: cover property (pslverr);
  c_lane_one_only: cover property (wr_prst && pstrb[1] && !pstrb[0]);

endmodule : sys_remap_and_periph_reset

// *** sim/periph_side_model.sv ***
// Far-side model: memory decoder fetch address and peripheral reset sinks.
// Assumes the bench names the fetch address; one system clock.
module periph_side_model (
  // Clock
  input wire logic clock,
  // Decoder side
  input wire logic [31:0] want_addr,
  output logic [31:0] mem_addr,
  // Reset sinks
  input wire logic [12:0] rst_n,
  output logic [12:0] in_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  initial mem_addr = 32'h0000_0000;
  // Fetch address moves only after an edge, as a real decoder would
  always @(posedge clock)
  begin
    mem_addr <= want_addr;
  end
  assign in_reset = ~rst_n;
endmodule : periph_side_model

// *** sim/sys_remap_and_periph_reset_test.sv ***
// Bench for the remap and soft reset bank: APB tasks, mode and reset-bit sequences.
// Assumes the far-side model is compiled first; bus waits are not assumed.
`include "sys_remap_defs.svh"
module sys_remap_and_periph_reset_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, vec_redirect, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, want_addr = 32'h0, prdata, mem_addr, rd;
  logic [3:0] pstrb = 4'hF;
  logic [1:0] sel_out;
  logic [12:0] rst_n, in_reset;
  sys_remap_pkg::mem_src_t mem_src;
  int errors = 0, n_compared = 0, i, k;
  sys_remap_and_periph_reset dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_src(mem_src), .vec_redirect(vec_redirect),
    .vector_region_source_select(sel_out), .first_serial_periph_reset_n(rst_n[0]),
    .second_serial_periph_reset_n(rst_n[1]), .baud_fraction_gen_reset_n(rst_n[2]),
    .first_async_port_reset_n(rst_n[3]), .second_async_port_reset_n(rst_n[4]),
    .third_async_port_reset_n(rst_n[5]), .i2c_reset_n(rst_n[6]), .multi_rate_timer_reset_n(rst_n[7]),
    .state_timer_reset_n(rst_n[8]), .wakeup_timer_reset_n(rst_n[9]), .gpio_reset_n(rst_n[10]),
    .flash_ctrl_reset_n(rst_n[11]), .comparator_reset_n(rst_n[12]));
  periph_side_model far (.clock(clock), .want_addr(want_addr), .mem_addr(mem_addr), .rst_n(rst_n),
    .in_reset(in_reset));
  initial
  begin
    forever #50 clock = ~clock;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Waits on pready itself; the slave latency is never assumed
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clock);
  endtask : apb
  task look(input logic [31:0] a);
    @(posedge clock);
    want_addr <= a;
    @(posedge clock);
    @(negedge clock);
  endtask : look
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    #(100 * 5000);
    errors++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, `VEC_SRC_SEL_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h2);
    apb(1'b0, `PERIPH_RST_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h1FFF);
    look(32'h0);
    chk(32'(mem_src), 32'h2);
    $display("test 1 done");
    for (k = 0; k < 3; k++)
    begin
      apb(1'b1, `VEC_SRC_SEL_ADDR, 32'hFFFF_FFF0 | 32'(k), 4'hF);
      apb(1'b0, `VEC_SRC_SEL_ADDR, 32'h0, 4'hF);
      chk(rd, 32'(k));
      look(32'h1FF);
      chk(32'(mem_src), 32'(k));
      chk(32'(vec_redirect), 32'(k != 2));
      look(32'h200);
      chk(32'(mem_src), 32'h2);
      chk(32'(vec_redirect), 32'h0);
    end
    // Reserved code and a strobe-less write must both leave flash selected
    apb(1'b1, `VEC_SRC_SEL_ADDR, 32'h3, 4'hF);
    apb(1'b1, `VEC_SRC_SEL_ADDR, 32'h1, 4'h0);
    chk(32'(sel_out), 32'h2);
    $display("test 2 done");
    for (i = 0; i < 13; i++)
    begin
      apb(1'b1, `PERIPH_RST_ADDR, ~(32'h1 << i), 4'hF);
      chk(32'(in_reset), 32'h1 << i);
      apb(1'b0, `PERIPH_RST_ADDR, 32'h0, 4'hF);
      chk(rd, 32'h1FFF & ~(32'h1 << i));
      chk(32'(rst_n), 32'h1FFF & ~(32'h1 << i));
    end
    apb(1'b1, `PERIPH_RST_ADDR, 32'hFFFF_FFFF, 4'hF);
    chk(32'(in_reset), 32'h0);
    apb(1'b0, `PERIPH_RST_ADDR, 32'h0, 4'hF);
    chk(rd, 32'h1FFF);
    $display("test 3 done");
    apb(1'b0, 32'h4004_8008, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `VEC_SRC_SEL_ADDR, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h0);
    apb(1'b1, `PERIPH_RST_ADDR, 32'h0, 4'h1);
    chk(32'(in_reset), 32'hFF);
    apb(1'b1, `PERIPH_RST_ADDR, 32'h0, 4'h2);
    chk(32'(in_reset), 32'h1FFF);
    chk(32'(sel_out), 32'h0);
    // Mid-run reset must bring flash back at once
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk(32'(sel_out), 32'h2);
    chk(32'(in_reset), 32'h0);
    $display("test 4 done");
    give_verdict();
  end
endmodule : sys_remap_and_periph_reset_test
